//--- oss_pkg.sv
// Package for the eight-channel low-side switch serial control block.
// Assumes a 100 MHz system clock that samples every pin of the serial link.
package oss_pkg;

    // Frame and channel geometry.
    localparam int CH_NUM = 8;
    localparam int MSB_POS = CH_NUM - 1;

    // Reset and forced values of the command latch, the shift register and the outputs.
    localparam logic [7:0] CMD_ALL_OFF = 8'hFF;
    localparam logic [7:0] SREG_CLEAR = 8'h00;
    localparam logic [7:0] STAT_ALL_OFF = 8'hFF;
    localparam logic [7:0] SWITCH_NONE = 8'h00;

    // Fault delay timer: least time, rounded up to whole clock cycles.
    localparam int CLK_PERIOD_PS = 10000;
    localparam int FAULT_DLY_US = 25;
    localparam int FAULT_DLY_PS = FAULT_DLY_US * 1000000;
    localparam int FAULT_DLY_CYC_I = (FAULT_DLY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int TMR_W = 12;
    localparam logic [TMR_W-1:0] FAULT_DLY_CYC = FAULT_DLY_CYC_I[TMR_W-1:0];
    localparam logic [TMR_W-1:0] TMR_IDLE = 12'h000;
    localparam logic [TMR_W-1:0] TMR_STEP = 12'h001;

    // Control pins of the serial link and the reset and protection pins.
    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic si;
        logic rst_n;
        logic short_latch_disable;
        logic load_supply_ov;
    } oss_ctl_pins_t;

    // Per-output analog sense results, one bit per channel.
    typedef struct packed {
        logic [7:0] drain_high;
        logic [7:0] over_current;
        logic [7:0] over_temp;
    } oss_sense_t;

endpackage : oss_pkg

//--- oss_serial_ctrl.sv
// Serial control logic of an eight-channel low-side switch.
// Assumes all pins are asynchronous to clk; the serial clock is far slower than clk.
// Every pin passes a two-flop synchroniser, so each pin event is acted on three
// clocks late; the serial clock must stay at each level for at least three clocks.
// Notes on behaviour
// - Serial data moves in and out only while chip select is low.
// - Chip select rising copies the shift register into the output latch.
// - Chip select falling loads the drain status of all outputs into the shift register.
// - Serial output driver turns on when chip select goes low.
// - Input sampled on serial clock falling; output updated on serial clock rising.
// - With chip select high, clock and input are ignored and output is released.
// - Command bit one switches an output off, zero switches it on.
// - Frames are eight bits, most significant first, first bit drives output seven.
// - Eight shifted bits leave exactly one whole command in the shift register.
// - Status bit is one for an unfaulted off output, zero for an on one.
// - Status goes out most significant first, alongside the incoming command.
// - Serial output pin ignores the reset input.
// - Reset low clears the shift register and turns all eight outputs off.
// - Short latch disable low latches a shorted output off; high keeps current limit.
// - After supply over-voltage the next frame returns all ones.
// - Chip select rising starts the fault delay; open-load detection waits for it.
`timescale 1ns/1ps

module oss_serial_ctrl (
    input wire logic clk,
    input wire logic sys_rst,
    input wire oss_pkg::oss_ctl_pins_t ctl_pins,
    input wire oss_pkg::oss_sense_t sense_pins,
    output logic so_data,
    output logic so_oe_n,
    output logic [7:0] switch_on
);

    // Two-stage synchronisers for every pin, plus a third stage for edge finding.
    oss_pkg::oss_ctl_pins_t ctl_s1_r;
    oss_pkg::oss_ctl_pins_t ctl_s2_r;
    oss_pkg::oss_sense_t sense_s1_r;
    oss_pkg::oss_sense_t sense_s2_r;
    logic cs_d_r;
    logic sclk_d_r;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctl_s1_r <= '{cs_n: 1'b1, rst_n: 1'b1, default: 1'b0};
            ctl_s2_r <= '{cs_n: 1'b1, rst_n: 1'b1, default: 1'b0};
            sense_s1_r <= '0;
            sense_s2_r <= '0;
            cs_d_r <= 1'b1;
            sclk_d_r <= 1'b0;
        end else begin
            ctl_s1_r <= ctl_pins;
            ctl_s2_r <= ctl_s1_r;
            sense_s1_r <= sense_pins;
            sense_s2_r <= sense_s1_r;
            cs_d_r <= ctl_s2_r.cs_n;
            sclk_d_r <= ctl_s2_r.sclk;
        end
    end

    // Synchronised levels and edges. Serial clock edges count only while the
    // synchronised chip select is low, so clock activity while deselected is ignored.
    wire cs_q = ctl_s2_r.cs_n;
    wire sclk_q = ctl_s2_r.sclk;
    wire si_q = ctl_s2_r.si;
    wire rst_q = ~ctl_s2_r.rst_n;
    wire sld_q = ctl_s2_r.short_latch_disable;
    wire ov_q = ctl_s2_r.load_supply_ov;
    wire cs_rise = cs_q & ~cs_d_r;
    wire cs_fall = ~cs_q & cs_d_r;
    wire sclk_rise = sclk_q & ~sclk_d_r & ~cs_q;
    wire sclk_fall = ~sclk_q & sclk_d_r & ~cs_q;
    wire clear_req = rst_q | ov_q;

    // State registers.
    logic [7:0] sreg_r;
    logic [7:0] sreg_nxt;
    logic [7:0] cmd_r;
    logic [7:0] cmd_nxt;
    logic [7:0] fault_off_r;
    logic [7:0] fault_off_nxt;
    logic ov_seen_r;
    logic ov_seen_nxt;
    logic [oss_pkg::TMR_W-1:0] tmr_r;
    logic [oss_pkg::TMR_W-1:0] tmr_nxt;
    logic so_r;
    logic so_nxt;
    logic so_oe_n_r;
    logic [7:0] switch_on_r;
    logic [7:0] switch_on_nxt;

    // Status word: drain high reads one, so an unfaulted off output gives one and
    // an unfaulted on output zero. While the fault delay runs, an off output whose
    // drain is still low is not yet reported as an open load.
    wire tmr_busy = (tmr_r != oss_pkg::TMR_IDLE);
    wire [7:0] open_mask = tmr_busy ? cmd_r : oss_pkg::SWITCH_NONE;
    wire [7:0] drain_stat = sense_s2_r.drain_high | open_mask;
    wire [7:0] status_w = ov_seen_r ? oss_pkg::STAT_ALL_OFF : drain_stat;

    // Shift register: reset and over-voltage clear it, chip select falling loads
    // status, and each serial clock falling edge shifts the input in at the bottom
    // so that the first bit sent ends in the top position for output seven.
    assign sreg_nxt = clear_req ? oss_pkg::SREG_CLEAR :
                      cs_fall ? status_w :
                      sclk_fall ? {sreg_r[6:0], si_q} :
                      sreg_r;

    // Output latch: forced off during reset and over-voltage, otherwise it only
    // changes at chip select rising, where a one bit means off.
    assign cmd_nxt = clear_req ? oss_pkg::CMD_ALL_OFF :
                     cs_rise ? sreg_r :
                     cmd_r;

    // Short latch-off per output; a new chip select rising re-arms it, but a short
    // seen in that same cycle still wins over the re-arm.
    wire [7:0] short_set;
    for (genvar ch = 0; ch < oss_pkg::CH_NUM; ch = ch + 1) begin : g_short
        assign short_set[ch] = ~sld_q & sense_s2_r.over_current[ch] & switch_on_r[ch];
    end
    assign fault_off_nxt = short_set | (fault_off_r & ~{8{cs_rise}});

    // Over-voltage is remembered until the following frame has loaded its status.
    assign ov_seen_nxt = ov_q | (ov_seen_r & ~cs_fall);

    // Fault delay timer restarts on every chip select rising edge.
    assign tmr_nxt = cs_rise ? oss_pkg::FAULT_DLY_CYC :
                     tmr_busy ? tmr_r - oss_pkg::TMR_STEP : tmr_r;

    // Serial output moves on serial clock rising only; reset does not touch it.
    assign so_nxt = sclk_rise ? sreg_r[oss_pkg::MSB_POS] : so_r;

    // Gate drive: on when commanded on and no latch-off, over-temperature, reset or over-voltage.
    assign switch_on_nxt = ~cmd_nxt & ~fault_off_nxt & ~sense_s2_r.over_temp
                           & ~{8{clear_req}};

    // State update; sys_rst is the only clear that also resets the timer and flags.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sreg_r <= oss_pkg::SREG_CLEAR;
            cmd_r <= oss_pkg::CMD_ALL_OFF;
            fault_off_r <= oss_pkg::SWITCH_NONE;
            ov_seen_r <= 1'b0;
            tmr_r <= oss_pkg::TMR_IDLE;
            switch_on_r <= oss_pkg::SWITCH_NONE;
        end else begin
            sreg_r <= sreg_nxt;
            cmd_r <= cmd_nxt;
            fault_off_r <= fault_off_nxt;
            ov_seen_r <= ov_seen_nxt;
            tmr_r <= tmr_nxt;
            switch_on_r <= switch_on_nxt;
        end
    end

    // Serial output pin registers, deliberately independent of the reset pin.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            so_r <= 1'b0;
            so_oe_n_r <= 1'b1;
        end else begin
            so_r <= so_nxt;
            so_oe_n_r <= cs_q;
        end
    end

    assign so_data = so_r;
    assign so_oe_n = so_oe_n_r;
    assign switch_on = switch_on_r;

    // Checks on the behaviour above.
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    AST_SO_RELEASED: assert property (cs_q |=> so_oe_n_r)
        else $error("Serial output driven while chip select is high.");

    AST_SO_ENABLED: assert property (cs_fall |=> !so_oe_n_r [*2])
        else $error("Serial output not enabled after chip select fell.");

    AST_LATCH_ON_RISE: assert property (
        cs_rise && !clear_req |=> cmd_r == $past(sreg_r))
        else $error("Output latch did not take the shift register at chip select rise.");

    AST_LATCH_HOLD: assert property (
        !cs_rise && !clear_req |=> $stable(cmd_r))
        else $error("Output latch changed outside a chip select rise.");

    AST_STATUS_LOAD: assert property (
        cs_fall && !clear_req |=> sreg_r == $past(status_w))
        else $error("Status was not loaded at chip select fall.");

    AST_SHIFT_IN: assert property (
        sclk_fall && !clear_req && !cs_fall
        |=> sreg_r == {$past(sreg_r[6:0]), $past(si_q)})
        else $error("Serial input not shifted in on clock fall.");

    AST_IGNORE_IDLE: assert property (
        cs_q && !cs_fall && !clear_req |=> $stable(sreg_r) && $stable(so_r))
        else $error("Shift register moved while chip select was high.");

    AST_SO_UPDATE: assert property (
        sclk_rise |=> so_r == $past(sreg_r[7]))
        else $error("Serial output did not present the top bit on clock rise.");

    AST_RESET_OFF: assert property (
        rst_q |=> switch_on_r == oss_pkg::SWITCH_NONE && sreg_r == oss_pkg::SREG_CLEAR)
        else $error("Reset did not clear the register and turn the outputs off.");

    AST_OV_STATUS: assert property (
        ov_seen_r && cs_fall && !clear_req |=> sreg_r == oss_pkg::STAT_ALL_OFF)
        else $error("First frame after over-voltage did not return all ones.");

    AST_SHORT_LATCH: assert property (
        !sld_q && sense_s2_r.over_current[0] && switch_on_r[0]
        |=> !switch_on_r[0] ##1 (!switch_on_r[0] || $past(cs_rise)))
        else $error("Shorted output was not latched off.");

    AST_TIMER_START: assert property (
        cs_rise |=> tmr_r == oss_pkg::FAULT_DLY_CYC ##1 tmr_r != oss_pkg::TMR_IDLE)
        else $error("Fault delay timer did not start at chip select rise.");

    // Gate drive against the latched command.
    AST_OFF_BIT: assert property (
        cs_rise && !clear_req |=> (switch_on_r & $past(sreg_r)) == oss_pkg::SWITCH_NONE)
        else $error("An output commanded off was switched on.");

    AST_ON_BIT: assert property (
        cs_rise && !clear_req && !(|sense_s2_r.over_temp) && !(|sense_s2_r.over_current)
        |=> switch_on_r == ~$past(sreg_r))
        else $error("An output commanded on was not switched on.");

    AST_RESET_LATCH: assert property (rst_q |=> cmd_r == oss_pkg::CMD_ALL_OFF)
        else $error("Output latch not forced off during reset.");

    // Serial output pin, which the reset pin must leave alone.
    AST_SO_STILL: assert property (!sclk_rise |=> $stable(so_r))
        else $error("Serial output moved without a serial clock rise.");

    AST_OE_IN_RESET: assert property (rst_q && !cs_q |=> !so_oe_n_r)
        else $error("Reset pin disabled the serial output driver.");

    // Shift register and status contents.
    AST_SREG_STILL: assert property (
        !sclk_fall && !cs_fall && !clear_req |=> $stable(sreg_r))
        else $error("Shift register moved without a serial clock fall.");

    AST_OPEN_MASKED: assert property (
        tmr_busy && cs_fall && !clear_req && !ov_seen_r
        |=> (sreg_r & $past(cmd_r)) == $past(cmd_r))
        else $error("Open load reported while the fault delay was running.");

    AST_OPEN_REPORT: assert property (
        !tmr_busy && cs_fall && !clear_req && !ov_seen_r
        |=> sreg_r == $past(sense_s2_r.drain_high))
        else $error("Status word does not follow the drain levels.");

    // Protection paths.
    AST_OV_OFF: assert property (
        ov_q |=> switch_on_r == oss_pkg::SWITCH_NONE && sreg_r == oss_pkg::SREG_CLEAR)
        else $error("Over-voltage did not shut all outputs down.");

    AST_OV_LATCH: assert property (ov_q |=> cmd_r == oss_pkg::CMD_ALL_OFF)
        else $error("Over-voltage did not force the output latch off.");

    AST_OV_FLAG_CLEAR: assert property (
        ov_seen_r && cs_fall && !ov_q |=> !ov_seen_r)
        else $error("Over-voltage report outlived the frame that carried it.");

    AST_LIMIT_MODE: assert property (
        sld_q && switch_on_r[0] && !fault_off_r[0] && !cs_rise && !clear_req
        && !sense_s2_r.over_temp[0] |=> switch_on_r[0])
        else $error("Output left current-limit mode although latch-off was disabled.");

    AST_SHORT_ANY: assert property (
        !sld_q && |(sense_s2_r.over_current & switch_on_r)
        |=> (switch_on_r & $past(sense_s2_r.over_current & switch_on_r)) == 8'h00)
        else $error("A shorted output stayed on with latch-off selected.");

    AST_OT_OFF: assert property (
        |sense_s2_r.over_temp
        |=> (switch_on_r & $past(sense_s2_r.over_temp)) == oss_pkg::SWITCH_NONE)
        else $error("Over-temperature did not turn the hot output off.");

    // Fault delay timer bounds; a runaway count would mask open loads for good.
    AST_TIMER_BOUND: assert property (tmr_r <= oss_pkg::FAULT_DLY_CYC)
        else $error("Fault delay timer ran past its load value.");

    AST_TIMER_QUIET: assert property (!tmr_busy && !cs_rise |=> !tmr_busy)
        else $error("Fault delay timer started without a chip select rise.");

    // Main scenarios that the bench is expected to reach.
    COV_FRAME: cover property (cs_fall ##[1:300] sclk_fall ##[1:300] cs_rise);
    COV_OV_FRAME: cover property (ov_seen_r && cs_fall && !clear_req);
    COV_SHORT: cover property (!sld_q && |short_set);
    COV_RESET: cover property (rst_q ##1 !rst_q);
    COV_LIMIT: cover property (sld_q && |(sense_s2_r.over_current & switch_on_r));

endmodule : oss_serial_ctrl

//--- oss_ctl_model.sv
// Serial bus controller model that sends one command byte per frame.
// Assumes the device samples its pins with a much faster clock of its own.
`timescale 1ns/1ps

module oss_ctl_model (
    output logic cs_n,
    output logic sclk,
    output logic si,
    input wire logic so
);
    // Idle pins: select high, clock parked low between frames.
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        si = 1'b0;
    end

    // One frame at a 125 ns clock; input moves mid-high so it is stable at both edges.
    task automatic xfer(input logic [7:0] cmd, output logic [7:0] rx);
        cs_n = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            #62.5 sclk = 1'b1;
            #31.25 si = cmd[i];
            #31.25 rx[i] = so;
            sclk = 1'b0;
        end
        #62.5 cs_n = 1'b1;
        si = ~si; // Released line shows a changed level, not the last bit.
        #62.5;
    endtask

    // Clock and input activity with select high, which the device must ignore.
    task automatic idle_clock(input int n);
        repeat (n) begin
            #50 sclk = 1'b1;
            si = ~si;
            #50 sclk = 1'b0;
        end
    endtask
endmodule // oss_ctl_model

//--- oss_serial_ctrl_tb.sv
// Self-checking bench for the serial control of the eight-output switch.
// Assumes the controller model drives the link; the bench drives all other pins.
`timescale 1ns/1ps

module oss_serial_ctrl_tb;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic rst_n = 1'b0;
    logic sld = 1'b0;
    logic ov = 1'b0;
    oss_pkg::oss_sense_t sense = '0;
    oss_pkg::oss_ctl_pins_t ctl;
    wire cs_n;
    wire sclk;
    wire si;
    logic so_data;
    logic so_oe_n;
    logic [7:0] sw;
    logic [7:0] rx;
    int n_mismatch = 0;
    int cmp_count = 0;
    int cyc = 0;

    // Pin bundle in struct order.
    assign ctl = {cs_n, sclk, si, rst_n, sld, ov};

    // The serial output has no pull, so while released the line reads as the
    // opposite of the last driven bit rather than holding it.
    wire so_line = so_oe_n ? ~so_data : so_data;

    oss_serial_ctrl u_dut (.clk(clk), .sys_rst(sys_rst), .ctl_pins(ctl),
        .sense_pins(sense), .so_data(so_data), .so_oe_n(so_oe_n), .switch_on(sw));
    oss_ctl_model u_ctl (.cs_n(cs_n), .sclk(sclk), .si(si), .so(so_line));

    always #5 clk = ~clk;

    // Hang guard; the whole run needs well under a tenth of this.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            n_mismatch++;
            end_of_test();
        end
    end

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // A frame also checks that the output driver is on while selected.
    task automatic frame(input logic [7:0] cmd);
        fork
            u_ctl.xfer(cmd, rx);
            begin
                tick(20);
                check("so_oe_n in frame", 8'h00, so_oe_n);
            end
        join
        tick(6);
        check("so_oe_n idle", 8'h01, so_oe_n);
    endtask

    task automatic t_frames();
        sense.drain_high = 8'h1C;
        frame(8'h35);
        check("status", 8'h1C, rx);
        check("switch_on", 8'hCA, sw);
        sense.drain_high = 8'h00;
        frame(8'hA5);
        check("status in delay", 8'h35, rx);
        tick(2600);
        frame(8'hA5);
        check("status after delay", 8'h00, rx);
        $display("frames done");
    endtask

    // Clock activity while deselected must leave the outputs alone.
    task automatic t_ignore();
        u_ctl.idle_clock(4);
        tick(5);
        check("switch_on idle", 8'h5A, sw);
        check("so_oe_n idle", 8'h01, so_oe_n);
        $display("ignore done");
    endtask

    task automatic t_rst();
        rst_n = 1'b0;
        tick(30);
        check("switch_on in reset", 8'h00, sw);
        check("so_oe_n in reset", 8'h01, so_oe_n);
        frame(8'h00);
        check("status in reset", 8'h00, rx);
        check("switch_on reset frame", 8'h00, sw);
        rst_n = 1'b1;
        tick(5);
        check("switch_on after reset", 8'h00, sw);
        frame(8'hF0);
        check("switch_on relatch", 8'h0F, sw);
        $display("reset done");
    endtask

    // A short latches the output off only with the latch-off mode selected.
    task automatic t_short();
        sense.over_current = 8'h01;
        tick(10);
        check("short latch", 8'h0E, sw);
        sense.over_current = 8'h00;
        tick(10);
        check("short held", 8'h0E, sw);
        frame(8'hF0);
        sld = 1'b1;
        sense.over_current = 8'h01;
        tick(10);
        check("current limit", 8'h0F, sw);
        sense.over_current = 8'h00;
        sense.over_temp = 8'h02;
        tick(10);
        check("over temp", 8'h0D, sw);
        sense.over_temp = 8'h00;
        tick(10);
        check("over temp gone", 8'h0F, sw);
        $display("short done");
    endtask

    task automatic t_ov();
        ov = 1'b1;
        tick(10);
        check("switch_on ov", 8'h00, sw);
        ov = 1'b0;
        tick(5);
        frame(8'h00);
        check("status after ov", 8'hFF, rx);
        check("switch_on all", 8'hFF, sw);
        $display("overvoltage done");
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        tick(10);
        sys_rst = 1'b0;
        tick(3);
        check("switch_on reset", 8'h00, sw);
        rst_n = 1'b1;
        tick(5);
        t_frames();
        t_ignore();
        t_rst();
        t_short();
        t_ov();
        end_of_test();
    end
endmodule // oss_serial_ctrl_tb
